// File: rtl/lcd_cmd_pkg.sv
/*
  Shared constants for the character LCD command interpreter: APB
  register offsets, command field positions, scan timing counts and
  reset values. Assumes nothing of its surroundings.
*/
package lcd_cmd_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CMD     = 8'h00;
  localparam logic [7:0] OFF_CHAR    = 8'h04;
  localparam logic [7:0] OFF_ADDR    = 8'h08;
  localparam logic [7:0] OFF_CONFIG  = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_OFFSETS = 8'h14;

  // Command bit positions
  localparam int BIT_EXT_SEL  = 2;
  localparam int BIT_SCROLL   = 1;
  localparam int BIT_INVERT   = 0;
  localparam int BIT_DIR_R    = 2;
  localparam int BIT_SEG_FLIP = 0;

  // Command opcode patterns on the upper bits
  localparam logic [4:0] OPC_FUNC_SET  = 5'h07; // bits 7..3
  localparam logic [3:0] OPC_SHIFT_EN  = 4'h1;  // bits 7..4
  localparam logic [4:0] OPC_DISP_SHFT = 5'h03; // bits 7..3
  localparam logic [5:0] OPC_ENTRY     = 6'h01; // bits 7..2

  // Config register fields
  localparam int CFG_SIX_DOT  = 0;
  localparam int CFG_LINES_LO = 1;
  localparam int CFG_LP       = 3;
  localparam logic [3:0] CONFIG_RESET = 4'h0;

  // Line count codes held in config bits 2..1
  localparam logic [1:0] LINES_ONE = 2'h0;

  // Oscillator clocks per scan line
  localparam logic [7:0] LINE_CLK_17_FIVE = 8'd200;
  localparam logic [7:0] LINE_CLK_17_SIX  = 8'd240;
  localparam logic [7:0] LINE_CLK_33_FIVE = 8'd100;
  localparam logic [7:0] LINE_CLK_33_SIX  = 8'd120;
  localparam logic [7:0] LINE_CLK_LP_FIVE = 8'd60;
  localparam logic [7:0] LINE_CLK_LP_SIX  = 8'd72;

  // Common lines per frame for each duty
  localparam logic [5:0] COMS_DUTY_17 = 6'd17;
  localparam logic [5:0] COMS_DUTY_33 = 6'd33;

  // Character memory and per-line shift geometry
  localparam int         MEM_DEPTH  = 80;
  localparam logic [6:0] MEM_LAST   = 7'd79;
  localparam int         NUM_LINES  = 4;
  localparam logic [4:0] LINE_LEN   = 5'd20;

endpackage

// File: rtl/line_offset.sv
/*
  Display shift position of one text line, wrapping over the line
  length. Assumes one-cycle shift pulses from the command decoder.
*/
`timescale 1ns/1ps
module line_offset (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       sel,
  input  wire logic       left,
  input  wire logic       right,
  output logic [4:0]      offset
);
  // Left steps down, right steps up, both wrap at the line length
  always_ff @(posedge clk) begin
    if (srst) begin
      offset <= 5'h00;
    end else if (ce && sel && left) begin
      offset <= (offset == 5'h00) ? lcd_cmd_pkg::LINE_LEN - 5'h01
                                  : offset - 5'h01;
    end else if (ce && sel && right) begin
      offset <= (offset == lcd_cmd_pkg::LINE_LEN - 5'h01) ? 5'h00
                                                          : offset + 5'h01;
    end
  end
endmodule

// File: rtl/scan_timer.sv
/*
  Scan line and frame timer. Counts enabled clocks as oscillator
  clocks. Assumes period and common count are held stable by caller.
*/
`timescale 1ns/1ps
module scan_timer (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic [7:0] period,
  input  wire logic [5:0] commons,
  output logic            line_pulse,
  output logic            frame_pulse,
  output logic [5:0]      com_index
);
  logic [7:0] clk_cnt;
  logic       line_end;

  assign line_end = (clk_cnt >= period - 8'h01);

  // Line counter; a new period that the count has already reached ends the line at once
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_cnt    <= 8'h00;
      line_pulse <= 1'b0;
    end else if (ce) begin
      clk_cnt    <= line_end ? 8'h00 : clk_cnt + 8'h01;
      line_pulse <= line_end;
    end
  end

  // Common index steps once per line and wraps at the duty count
  always_ff @(posedge clk) begin
    if (srst) begin
      com_index   <= 6'h00;
      frame_pulse <= 1'b0;
    end else if (ce) begin
      frame_pulse <= 1'b0;
      if (line_end) begin
        if (com_index >= commons - 6'h01) begin
          com_index   <= 6'h00;
          frame_pulse <= 1'b1;
        end else begin
          com_index <= com_index + 6'h01;
        end
      end
    end
  end
endmodule

// File: rtl/lcd_cmd_core.sv
/*
  Character LCD command interpreter and scan timing, reached over
  APB. Commands and character codes arrive as register writes.
  Assumes a single clock, a synchronous active-high reset and an
  APB master that holds each request until PREADY.
*/
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps

module lcd_cmd_core (
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             LINE_STROBE,
  output logic             FRAME_STROBE,
  output logic [5:0]       COM_INDEX,
  output logic             DUTY_33,
  output logic             INVERTED_DISPLAY,
  output logic             SEGMENT_ORDER_FLIP
);
  logic [7:0]  char_code_memory [lcd_cmd_pkg::MEM_DEPTH];
  logic [7:0]  last_cmd;
  logic [6:0]  addr;
  logic [3:0]  config_bits;
  logic        extended_set_select;
  logic        line_scroll_allow;
  logic [3:0]  shift_allow;
  logic        shift_l;
  logic        shift_r;
  logic [3:0]  line_sel;
  logic [4:0]  offs [lcd_cmd_pkg::NUM_LINES];
  logic [7:0]  line_period;
  logic [5:0]  commons;
  logic        slow_scan_power_save;
  logic        wr_fire;
  logic        cmd_wr;
  logic        char_wr;
  logic [7:0]  cb;
  logic        is_func_set;
  logic        is_shift_en;
  logic        is_disp_shift;
  logic        is_entry;
  logic        mapped;
  logic [31:0] next_rdata;

  // Requests take effect only at the edge that completes the access
  assign wr_fire = CE & PSEL & PENABLE & PWRITE & PREADY;
  assign cmd_wr  = wr_fire && (PADDR == lcd_cmd_pkg::OFF_CMD);
  assign char_wr = wr_fire && (PADDR == lcd_cmd_pkg::OFF_CHAR);
  assign cb      = PWDATA[7:0];

  // Command decode; the extended flag picks between overlapping codes
  assign is_func_set   = cmd_wr && (cb[7:3] == lcd_cmd_pkg::OPC_FUNC_SET);
  assign is_shift_en   = cmd_wr && extended_set_select &&
                         (cb[7:4] == lcd_cmd_pkg::OPC_SHIFT_EN);
  assign is_disp_shift = cmd_wr && !extended_set_select &&
                         (cb[7:3] == lcd_cmd_pkg::OPC_DISP_SHFT);
  assign is_entry      = cmd_wr && extended_set_select &&
                         (cb[7:2] == lcd_cmd_pkg::OPC_ENTRY);

  assign slow_scan_power_save = config_bits[lcd_cmd_pkg::CFG_LP];

  // Flags hold until the next command of their kind
  // Function set: extended flag, then scroll and inversion when bit 2 is clear
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      extended_set_select <= 1'b0;
      line_scroll_allow   <= 1'b0;
      INVERTED_DISPLAY    <= 1'b0;
    end else if (is_func_set) begin
      extended_set_select <= cb[lcd_cmd_pkg::BIT_EXT_SEL];
      if (!cb[lcd_cmd_pkg::BIT_EXT_SEL]) begin
        line_scroll_allow <= cb[lcd_cmd_pkg::BIT_SCROLL];
        INVERTED_DISPLAY  <= cb[lcd_cmd_pkg::BIT_INVERT];
      end
    end
  end

  // Per-line shift enables; bit 3 is the fourth line
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      shift_allow <= 4'h0;
    end else if (is_shift_en) begin
      shift_allow <= cb[3:0];
    end
  end

  // Segment order flip from the extended entry mode
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      SEGMENT_ORDER_FLIP <= 1'b0;
    end else if (is_entry) begin
      SEGMENT_ORDER_FLIP <= cb[lcd_cmd_pkg::BIT_SEG_FLIP];
    end
  end

  // Shift pulses; bits 1..0 of the command play no part
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      shift_l <= 1'b0;
      shift_r <= 1'b0;
    end else if (CE) begin
      shift_l <= is_disp_shift && !cb[lcd_cmd_pkg::BIT_DIR_R];
      shift_r <= is_disp_shift && cb[lcd_cmd_pkg::BIT_DIR_R];
    end
  end

  // Without per-line scrolling the whole display moves together
  assign line_sel = line_scroll_allow ? shift_allow : 4'hF;

  genvar gi;
  generate
    for (gi = 0; gi < lcd_cmd_pkg::NUM_LINES; gi++) begin : g_line
      line_offset u_line (
        .clk    (CLK_SYS),
        .srst   (SRST),
        .ce     (CE),
        .sel    (line_sel[gi]),
        .left   (shift_l),
        .right  (shift_r),
        .offset (offs[gi])
      );
    end
  endgenerate

  // Character store with address auto-increment wrapping at the end
  always_ff @(posedge CLK_SYS) begin
    if (char_wr) begin
      char_code_memory[addr] <= cb;
    end
  end

  // Address counter; writes to it beyond the last cell are clamped
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      addr <= 7'h00;
    end else if (char_wr) begin
      addr <= (addr == lcd_cmd_pkg::MEM_LAST) ? 7'h00 : addr + 7'h01;
    end else if (wr_fire && PADDR == lcd_cmd_pkg::OFF_ADDR) begin
      addr <= (PWDATA[6:0] > lcd_cmd_pkg::MEM_LAST) ?
              lcd_cmd_pkg::MEM_LAST : PWDATA[6:0];
    end
  end

  // Config and last command, kept for read-back
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      config_bits <= lcd_cmd_pkg::CONFIG_RESET;
      last_cmd    <= 8'h00;
    end else begin
      if (wr_fire && PADDR == lcd_cmd_pkg::OFF_CONFIG) begin
        config_bits <= PWDATA[3:0];
      end
      if (cmd_wr) begin
        last_cmd <= cb;
      end
    end
  end

  // Duty from line count, scan line length from duty, font, power
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      DUTY_33     <= 1'b0;
      line_period <= lcd_cmd_pkg::LINE_CLK_17_FIVE;
      commons     <= lcd_cmd_pkg::COMS_DUTY_17;
    end else if (CE) begin
      DUTY_33 <= (config_bits[2:1] != lcd_cmd_pkg::LINES_ONE);
      commons <= DUTY_33 ? lcd_cmd_pkg::COMS_DUTY_33
                         : lcd_cmd_pkg::COMS_DUTY_17;
      if (slow_scan_power_save) begin
        line_period <= config_bits[0] ? lcd_cmd_pkg::LINE_CLK_LP_SIX
                                      : lcd_cmd_pkg::LINE_CLK_LP_FIVE;
      end else if (DUTY_33) begin
        line_period <= config_bits[0] ? lcd_cmd_pkg::LINE_CLK_33_SIX
                                      : lcd_cmd_pkg::LINE_CLK_33_FIVE;
      end else begin
        line_period <= config_bits[0] ? lcd_cmd_pkg::LINE_CLK_17_SIX
                                      : lcd_cmd_pkg::LINE_CLK_17_FIVE;
      end
    end
  end

  // Frame = line period times commons, one oscillator clock
  scan_timer u_scan (
    .clk         (CLK_SYS),
    .srst        (SRST),
    .ce          (CE),
    .period      (line_period),
    .commons     (commons),
    .line_pulse  (LINE_STROBE),
    .frame_pulse (FRAME_STROBE),
    .com_index   (COM_INDEX)
  );

  // Read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    next_rdata = 32'h0000_0000;
    mapped     = 1'b1;
    case (PADDR)
      lcd_cmd_pkg::OFF_CMD:     next_rdata[7:0] = last_cmd;
      lcd_cmd_pkg::OFF_CHAR:    next_rdata[7:0] = char_code_memory[addr];
      lcd_cmd_pkg::OFF_ADDR:    next_rdata[6:0] = addr;
      lcd_cmd_pkg::OFF_CONFIG:  next_rdata[3:0] = config_bits;
      lcd_cmd_pkg::OFF_STATUS:  next_rdata[8:0] = {DUTY_33, shift_allow,
                                  SEGMENT_ORDER_FLIP, INVERTED_DISPLAY,
                                  line_scroll_allow, extended_set_select};
      lcd_cmd_pkg::OFF_OFFSETS: next_rdata = {3'h0, offs[3], 3'h0, offs[2],
                                  3'h0, offs[1], 3'h0, offs[0]};
      default:                  mapped = 1'b0;
    endcase
  end

  // One wait state: PREADY rises in the second access cycle
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (CE) begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        PRDATA <= next_rdata;
      end
    end
  end

  // Checks
  default clocking cb_sys @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  // Names used by the checks below
  localparam logic [4:0] LINE_LEN_M1 = lcd_cmd_pkg::LINE_LEN - 5'h01;
  localparam logic [7:0] LP_FIVE     = lcd_cmd_pkg::LINE_CLK_LP_FIVE;
  localparam logic [7:0] LP_SIX      = lcd_cmd_pkg::LINE_CLK_LP_SIX;
  localparam logic [6:0] ADDR_LAST   = lcd_cmd_pkg::MEM_LAST;

  // Clocks since the last line strobe; only a line begun and ended
  // under one period is timed, since a change may cut a line short
  logic [7:0] gap;
  logic       gap_valid;
  always_ff @(posedge CLK_SYS) begin
    if (SRST || (line_period != $past(line_period))) begin
      gap       <= 8'h00;
      gap_valid <= 1'b0;
    end else if (CE && LINE_STROBE) begin
      gap       <= 8'h00;
      gap_valid <= 1'b1;
    end else if (CE) begin
      gap <= gap + 8'h01;
    end
  end

  // Steps of a display shift: the command, then the pulse on line one
  sequence s_left_cmd;
    is_disp_shift && !cb[2];
  endsequence
  sequence s_left_step;
    shift_l && line_sel[0] && CE;
  endsequence
  sequence s_right_cmd;
    is_disp_shift && cb[2];
  endsequence
  sequence s_right_step;
    shift_r && line_sel[0] && CE;
  endsequence

  // Command decode
  chk_ext_flag: assert property (
    is_func_set |=> extended_set_select == $past(PWDATA[2]))
    else $error("extended flag not taken from function set");
  chk_ext_keeps: assert property (
    is_func_set && cb[2] |=> $stable(line_scroll_allow) &&
      $stable(INVERTED_DISPLAY))
    else $error("extended function set changed scroll or inversion");
  chk_scroll_set: assert property (
    is_func_set && !cb[2] |=> line_scroll_allow == $past(PWDATA[1]))
    else $error("scroll enable not updated");
  chk_invert_set: assert property (
    is_func_set && !cb[2] |=> INVERTED_DISPLAY == $past(PWDATA[0]))
    else $error("inversion not updated");
  chk_shift_allow: assert property (
    is_shift_en |=> shift_allow == $past(PWDATA[3:0]))
    else $error("shift enables not stored");
  chk_normal_keeps: assert property (
    cmd_wr && !extended_set_select |=> $stable(shift_allow) &&
      $stable(SEGMENT_ORDER_FLIP))
    else $error("extended setting changed in normal decoding");

  // Display shift and segment order
  chk_left_shift: assert property (
    s_left_cmd ##1 s_left_step |=>
      offs[0] == (($past(offs[0]) == 5'h00) ? LINE_LEN_M1
                                            : $past(offs[0]) - 5'h01))
    else $error("left shift did not step line one");
  chk_no_ext_shift: assert property (
    CE && extended_set_select |=> !shift_l && !shift_r)
    else $error("display shift decoded in extended mode");
  chk_right_shift: assert property (
    is_disp_shift && cb[2] |=> shift_r && !shift_l)
    else $error("right shift pulse missing");
  chk_right_step: assert property (
    s_right_cmd ##1 s_right_step |=>
      offs[0] == (($past(offs[0]) == LINE_LEN_M1) ? 5'h00
                                                  : $past(offs[0]) + 5'h01))
    else $error("right shift did not step line one");
  chk_seg_flip: assert property (
    is_entry |=> SEGMENT_ORDER_FLIP == $past(PWDATA[0]))
    else $error("segment order not latched");

  // Character store
  chk_char_store: assert property (
    char_wr |=> char_code_memory[$past(addr)] == $past(PWDATA[7:0]))
    else $error("character not stored");
  chk_addr_step: assert property (
    char_wr |=> addr == (($past(addr) == ADDR_LAST) ? 7'h00
                                                    : $past(addr) + 7'h01))
    else $error("address did not step after a character");

  // Scan timing and mode flag hold
  chk_line_len: assert property (
    CE && LINE_STROBE && gap_valid && $stable(line_period) |->
      gap == line_period - 8'h01)
    else $error("scan line length wrong");
  chk_lp_len: assert property (
    CE && slow_scan_power_save |=>
      line_period == ($past(config_bits[0]) ? LP_SIX : LP_FIVE))
    else $error("power save line length wrong");
  chk_duty_pick: assert property (
    CE |=> DUTY_33 == ($past(config_bits[2:1]) != 2'h0))
    else $error("duty does not follow line count");
  chk_mode_hold: assert property (
    !cmd_wr |=> $stable(extended_set_select) && $stable(shift_allow) &&
      $stable(INVERTED_DISPLAY) && $stable(SEGMENT_ORDER_FLIP))
    else $error("mode flag changed without command");
  chk_frame_end: assert property (
    FRAME_STROBE |-> LINE_STROBE && COM_INDEX == 6'h00)
    else $error("frame ended off a line boundary");
endmodule

// File: verif/apb_host.sv
/*
  APB host model standing in for the processor that feeds commands
  and character codes. Assumes one clock and a slave that answers
  with PREADY; a wait is cut off after a bounded count.
*/
`timescale 1ns/1ps
module apb_host (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // Request held until PREADY is seen at an edge, then released
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err, output bit tmo);
    int n;
    rd  = 32'h0;
    err = 1'b0;
    tmo = 1'b1;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        rd  = prdata;
        err = pslverr;
        tmo = 1'b0;
        break;
      end
    end
    // Released lines show garbage so stale values never look valid
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// File: verif/testbench.sv
/*
  Self-checking bench for the LCD command interpreter: a model of
  flags, line offsets and character memory is compared with every
  read, and scan strobes are timed. Assumes the APB host model.
*/
`timescale 1ns/1ps
module testbench;
  logic        clk, srst, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        line_strobe, frame_strobe, duty_33, inverted, seg_flip;
  logic [5:0]  com_index;
  int          n_fail, n_tests, ext, dh, inv, seg, en, duty;
  int          offs [4];
  int          mem [80];
  integer      seed;
  logic [7:0]  seq [14] = '{8'h3A, 8'h3C, 8'h18, 8'h3A, 8'h18, 8'h19,
                            8'h1A, 8'h1B, 8'h3B, 8'h1C, 8'h1F, 8'h38,
                            8'h3C, 8'h07};

  lcd_cmd_core u_dut (.CLK_SYS(clk), .SRST(srst), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LINE_STROBE(line_strobe), .FRAME_STROBE(frame_strobe),
    .COM_INDEX(com_index), .DUTY_33(duty_33),
    .INVERTED_DISPLAY(inverted), .SEGMENT_ORDER_FLIP(seg_flip));

  apb_host u_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("mismatches %0d of %0d comparisons", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic fail(input string msg);
    $display("wrong value at %0t: %s", $time, msg);
    n_fail++;
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
    n_tests++;
    if (got !== exp) fail($sformatf("%s %h not %h", what, got, exp));
  endtask

  task automatic check_pin(input logic got, input logic exp,
                           input string what);
    n_tests++;
    if (got !== exp) fail($sformatf("%s %b not %b", what, got, exp));
  endtask

  task automatic check_count(input int got, input int exp, input string w);
    n_tests++;
    if (got != exp) fail($sformatf("%s %0d not %0d", w, got, exp));
  endtask

  // Bus access; a slave that never answers ends the run
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    bit tmo;
    u_host.xfer(wr, a, d, rd, err, tmo);
    if (tmo) begin
      fail("no bus answer");
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic        e;
    bus(1'b1, a, d, v, e);
    check_pin(e, 1'b0, "write error");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string what);
    logic [31:0] v;
    logic        e;
    bus(1'b0, a, 32'h0, v, e);
    check_pin(e, 1'b0, "read error");
    check_reg(v, exp, what);
  endtask

  function automatic logic [31:0] status_word();
    return {23'h0, duty[0], en[3:0], seg[0], inv[0], dh[0], ext[0]};
  endfunction

  function automatic logic [31:0] offs_word();
    return {3'h0, offs[3][4:0], 3'h0, offs[2][4:0],
            3'h0, offs[1][4:0], 3'h0, offs[0][4:0]};
  endfunction

  // Reference decode; with scrolling off every line moves
  function automatic void apply_cmd(input logic [7:0] c);
    if (c[7:3] == 5'h07) begin
      ext = c[2];
      if (!c[2]) begin
        dh  = c[1];
        inv = c[0];
      end
    end else if (ext != 0) begin
      if (c[7:4] == 4'h1) en = c[3:0];
      else if (c[7:2] == 6'h01) seg = c[0];
    end else if (c[7:3] == 5'h03) begin
      for (int i = 0; i < 4; i++) begin
        if (dh == 0 || en[i]) offs[i] = (offs[i] + (c[2] ? 1 : 19)) % 20;
      end
    end
  endfunction

  // Reset held five cycles; memory keeps its contents
  task automatic do_reset();
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    {ext, dh, inv, seg, en, duty} = '0;
    offs = '{0, 0, 0, 0};
    @(posedge clk);
  endtask

  task automatic send_check(input logic [7:0] c);
    wr(lcd_cmd_pkg::OFF_CMD, {24'h0, c});
    apply_cmd(c);
    rd(lcd_cmd_pkg::OFF_STATUS, status_word(), "status");
    rd(lcd_cmd_pkg::OFF_OFFSETS, offs_word(), "offsets");
    rd(lcd_cmd_pkg::OFF_CMD, {24'h0, c}, "last command");
    check_pin(inverted, inv[0], "invert pin");
    check_pin(seg_flip, seg[0], "flip pin");
  endtask

  // Times one whole frame after the new period has settled
  task automatic scan(input int six, input int lines, input int lp);
    int p, com, cyc, last, nl, k;
    duty = (lines != 0);
    p = lp ? (six ? 72 : 60) : (duty ? (six ? 120 : 100) : (six ? 240 : 200));
    com = duty ? 33 : 17;
    wr(lcd_cmd_pkg::OFF_CONFIG, 32'(lp * 8 + lines * 2 + six));
    repeat (4) @(posedge clk);
    check_pin(duty_33, duty[0], "duty pin");
    for (k = 0; k < 9000 && frame_strobe !== 1'b1; k++) @(posedge clk);
    if (k == 9000) begin
      fail("no frame strobe");
      report_and_stop();
    end
    {cyc, last, nl} = '0;
    for (k = 0; k < 9000; k++) begin
      @(posedge clk);
      cyc++;
      if (line_strobe === 1'b1) begin
        check_count(cyc - last, p, "line period");
        check_reg(32'(com_index), 32'((nl + 1) % com), "common");
        last = cyc;
        nl++;
      end
      if (frame_strobe === 1'b1) break;
    end
    if (k == 9000) begin
      fail("frame never ended");
      report_and_stop();
    end
    check_count(nl, com, "lines per frame");
    check_count(cyc, p * com, "frame period");
    rd(lcd_cmd_pkg::OFF_STATUS, status_word(), "duty status");
  endtask

  initial begin
    int          k, c;
    logic [31:0] v;
    logic        e;
    n_fail  = 0;
    n_tests = 0;
    seed    = 32'hDC59;
    srst    = 1'b1;
    ce      = 1'b1;
    do_reset();
    check_pin(inverted, 1'b0, "invert after reset");
    check_pin(duty_33, 1'b0, "duty after reset");
    rd(lcd_cmd_pkg::OFF_STATUS, 32'h0, "status reset");
    rd(lcd_cmd_pkg::OFF_OFFSETS, 32'h0, "offsets reset");
    // Documented sequence, then random commands with random low bits
    for (k = 0; k < 14; k++) send_check(seq[k]);
    for (k = 0; k < 60; k++) send_check(8'($random(seed)) & 8'h3F);
    // Unmapped places refuse and leave state alone
    bus(1'b0, 8'h18, 32'h0, v, e);
    check_pin(e, 1'b1, "unmapped read");
    bus(1'b1, 8'h1C, 32'hFFFFFFFF, v, e);
    check_pin(e, 1'b1, "unmapped write");
    rd(lcd_cmd_pkg::OFF_STATUS, status_word(), "status kept");
    // Clock enable low freezes the scan position
    ce <= 1'b0;
    @(posedge clk);
    v = 32'(com_index);
    repeat (3) @(posedge clk);
    check_reg(32'(com_index), v, "frozen common");
    ce <= 1'b1;
    do_reset();
    rd(lcd_cmd_pkg::OFF_STATUS, 32'h0, "status second reset");
    // Character codes across the address wrap
    wr(lcd_cmd_pkg::OFF_ADDR, 32'h4E);
    for (k = 0; k < 3; k++) begin
      c = $random(seed) & 255;
      wr(lcd_cmd_pkg::OFF_CHAR, 32'(c));
      mem[(78 + k) % 80] = c;
    end
    rd(lcd_cmd_pkg::OFF_ADDR, 32'h1, "address wrap");
    for (k = 0; k < 3; k++) begin
      wr(lcd_cmd_pkg::OFF_ADDR, 32'((78 + k) % 80));
      rd(lcd_cmd_pkg::OFF_CHAR, 32'(mem[(78 + k) % 80]), "code");
    end
    wr(lcd_cmd_pkg::OFF_ADDR, 32'h64);
    rd(lcd_cmd_pkg::OFF_ADDR, 32'h4F, "address clamp");
    // Every font, power and duty setting; line codes picked at random
    for (k = 0; k < 8; k++) begin
      c = $random(seed) & 3;
      scan(k & 1, (k & 4) ? ((c == 0) ? 3 : c) : 0, (k >> 1) & 1);
    end
    report_and_stop();
  end
endmodule
